// *** common/ccsr_map.svh ***
`ifndef CCSR_MAP_SVH
`define CCSR_MAP_SVH

`define CCSR_ID_MSB      31
`define CCSR_ID_LSB      24
`define CCSR_REV_MSB     23
`define CCSR_REV_LSB     16
`define CCSR_PDREQ_MSB      15
`define CCSR_PDREQ_LSB      10
`define CCSR_SATURATION_BIT 9
`define CCSR_EN_BIT         8
`define CCSR_PCACHE_MSB     7
`define CCSR_PCACHE_LSB     5
`define CCSR_DCACHE_MSB     4
`define CCSR_DCACHE_LSB     2
`define CCSR_SAVED_EN_BIT   1
`define CCSR_GLOBAL_EN_BIT  0

`define CCSR_PD_NONE     6'h00
`define CCSR_PD_LIGHT_EN 6'h09
`define CCSR_PD_LIGHT_AN 6'h11
`define CCSR_PD_DEEPER   6'h1A
`define CCSR_PD_DEEPEST  6'h1C

`define CCSR_CACHE_ON_A  3'h0
`define CCSR_CACHE_ON_B  3'h2
`define CCSR_CACHE_RST   3'h0

`endif

// *** common/ccsr_pkg.sv ***
package ccsr_pkg;

    typedef enum logic [1:0] {
        CCSR_AWAKE   = 2'b00,
        CCSR_LIGHT   = 2'b01,
        CCSR_DEEPER  = 2'b11,
        CCSR_DEEPEST = 2'b10
    } ccsr_sleep_e;

    typedef struct packed {
        logic        wrEn;
        logic [31:0] wrData;
    } ccsr_move_s;

    typedef struct packed {
        logic [2:0] programCacheMode;
        logic [2:0] dataCacheMode;
        logic       programCacheOn;
        logic       dataCacheOn;
    } ccsr_cache_s;

endpackage

// *** rtl/ccsr_core_status.sv ***
`include "ccsr_map.svh"

// Operation
// - Top two bytes: read-only identifier, revision
// - Power-down field writable, always reads zero
// - 001001/010001 enter light sleep, interrupt wake
// - 011010/011100 deeper/deepest, reset wake only
// - Saturation set by units, cleared by move
// - Simultaneous set and clear leaves set
// - Saturation flag sets one cycle later
// - False-condition instruction leaves saturation unchanged
// - Bit 8 read-only endian, default little
// - Program cache 000/010 enabled, others reserved
// - Data cache 000/010 two-way enabled
// - Interrupt taken copies enable to saved bit
// - Bit 0 gates maskable interrupts only
module ccsr_core_status
    import ccsr_pkg::*;
#(
    parameter logic [7:0] CORE_ID  = 8'h5A, // Arbitrary value
    parameter logic [7:0] REV_ID   = 8'hA5, // Arbitrary value
    parameter int         NUM_INTS = 12
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire ccsr_move_s          moveWr,
    input  wire logic                moveRd,
    input  wire logic                satEvent,
    input  wire logic                satCondTrue,
    input  wire logic                intTaken,
    input  wire logic                intReturn,
    input  wire logic [NUM_INTS-1:0] intPending,
    input  wire logic [NUM_INTS-1:0] intEnabled,
    input  wire logic                endianPin,
    output logic [31:0]              rdData_q,
    output logic                     maskableAllow_q,
    output ccsr_sleep_e              sleepState_q,
    output ccsr_cache_s              cache_q
);

    if (NUM_INTS < 1 || NUM_INTS > 32) begin : g_bad_num_ints
        $error("NUM_INTS out of range");
    end

    function automatic logic cacheOn(input logic [2:0] mode);
        cacheOn = (mode == `CCSR_CACHE_ON_A) || (mode == `CCSR_CACHE_ON_B);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic       endianS1_q;
    logic       endianS2_q;
    logic       endian_q;
    logic [1:0] strapWait_q;
    logic       strapDone_q;
    logic       globalEn_q;
    logic       savedEn_q;
    logic       anyWake_q;
    logic [2:0] progCache_q;
    logic [2:0] dataCache_q;
    logic       satFlag;
    logic [5:0] pdReq;
    logic       wakeAny;
    logic       wakeEn;

    assign pdReq   = moveWr.wrData[`CCSR_PDREQ_MSB:`CCSR_PDREQ_LSB];
    assign wakeAny = |intPending;
    assign wakeEn  = |(intPending & intEnabled);

    ccsr_sat_flag u_sat (
        .clk         (clk),
        .nrst        (nrst),
        .satEvent    (satEvent),
        .satCondTrue (satCondTrue),
        .clearReq    (moveWr.wrEn),
        .clearValue  (moveWr.wrData[`CCSR_SATURATION_BIT]),
        .satFlag_q   (satFlag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Endian strap sync and capture after reset release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            endianS1_q <= 1'b1;
            endianS2_q <= 1'b1;
        end else begin
            endianS1_q <= endianPin;
            endianS2_q <= endianS1_q;
        end
    end

    // Wait until the synchroniser holds the strap before capturing it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            endian_q    <= 1'b1;
            strapWait_q <= 2'b00;
            strapDone_q <= 1'b0;
        end else if (!strapDone_q) begin
            strapWait_q <= {strapWait_q[0], 1'b1};
            if (strapWait_q[1]) begin
                endian_q    <= endianS2_q;
                strapDone_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enable and saved copy
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            globalEn_q <= 1'b0;
            savedEn_q  <= 1'b0;
        end else if (intTaken) begin
            savedEn_q  <= globalEn_q;
            globalEn_q <= 1'b0;
        end else if (intReturn) begin
            globalEn_q <= savedEn_q;
        end else if (moveWr.wrEn) begin
            globalEn_q <= moveWr.wrData[`CCSR_GLOBAL_EN_BIT];
            savedEn_q  <= moveWr.wrData[`CCSR_SAVED_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            maskableAllow_q <= 1'b0;
        end else begin
            maskableAllow_q <= globalEn_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cache modes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            progCache_q <= `CCSR_CACHE_RST;
            dataCache_q <= `CCSR_CACHE_RST;
        end else if (moveWr.wrEn) begin
            progCache_q <= moveWr.wrData[`CCSR_PCACHE_MSB:`CCSR_PCACHE_LSB];
            dataCache_q <= moveWr.wrData[`CCSR_DCACHE_MSB:`CCSR_DCACHE_LSB];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cache_q <= '0;
        end else begin
            cache_q.programCacheMode <= progCache_q;
            cache_q.dataCacheMode    <= dataCache_q;
            cache_q.programCacheOn   <= cacheOn(progCache_q);
            cache_q.dataCacheOn      <= cacheOn(dataCache_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-down state machine
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleepState_q <= CCSR_AWAKE;
        end else begin
            case (sleepState_q)
                CCSR_AWAKE: begin
                    if (moveWr.wrEn) begin
                        case (pdReq)
                            `CCSR_PD_LIGHT_EN: sleepState_q <= CCSR_LIGHT;
                            `CCSR_PD_LIGHT_AN: sleepState_q <= CCSR_LIGHT;
                            `CCSR_PD_DEEPER:   sleepState_q <= CCSR_DEEPER;
                            `CCSR_PD_DEEPEST:  sleepState_q <= CCSR_DEEPEST;
                            default:           sleepState_q <= CCSR_AWAKE;
                        endcase
                    end
                end
                CCSR_LIGHT: begin
                    if (anyWake_q ? wakeAny : wakeEn) begin
                        sleepState_q <= CCSR_AWAKE;
                    end
                end
                CCSR_DEEPER:  sleepState_q <= CCSR_DEEPER;
                CCSR_DEEPEST: sleepState_q <= CCSR_DEEPEST;
                default:      sleepState_q <= CCSR_AWAKE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            anyWake_q <= 1'b0;
        end else if (moveWr.wrEn && sleepState_q == CCSR_AWAKE) begin
            anyWake_q <= (pdReq == `CCSR_PD_LIGHT_AN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back word, registered on a move read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData_q <= 32'h0000_0000;
        end else if (moveRd) begin
            rdData_q <= {CORE_ID, REV_ID, 6'h00, satFlag, endian_q,
                         progCache_q, dataCache_q, savedEn_q, globalEn_q};
        end
    end

endmodule

// *** rtl/ccsr_sat_flag.sv ***
`include "ccsr_map.svh"

module ccsr_sat_flag
    import ccsr_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic satEvent,
    input  wire logic satCondTrue,
    input  wire logic clearReq,
    input  wire logic clearValue,
    output logic      satFlag_q
);

    logic satPend_q;

    // Delay slot stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            satPend_q <= 1'b0;
        end else begin
            satPend_q <= satEvent & satCondTrue;
        end
    end

    // Set wins over clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            satFlag_q <= 1'b0;
        end else if (satPend_q) begin
            satFlag_q <= 1'b1;
        end else if (clearReq && !clearValue) begin
            satFlag_q <= 1'b0;
        end
    end

endmodule

// *** verif/ccsr_core_status_chk.sv ***
module ccsr_core_status_chk
    import ccsr_pkg::*;
#(
    parameter logic [7:0] CORE_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] REV_ID  = 8'hA5  // Arbitrary value
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire ccsr_move_s  moveWr,
    input wire logic        moveRd,
    input wire logic        satEvent,
    input wire logic        satCondTrue,
    input wire logic        intTaken,
    input wire logic        intReturn,
    input wire logic        endianPin,
    input wire logic [31:0] rdData_q,
    input wire logic        maskableAllow_q,
    input wire ccsr_sleep_e sleepState_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic sat;
    logic quiet;
    assign sat   = satEvent && satCondTrue;
    assign quiet = !moveWr.wrEn && !intTaken && !intReturn;
    ////////////////////////////////////////////////////////////////
    chk_id_read: assert property (moveRd |=> rdData_q[31:16] == {CORE_ID, REV_ID})
        else $error("identifier field wrong");
    chk_powerdown_zero: assert property (rdData_q[15:10] == 6'h00)
        else $error("power-down field not zero");
    chk_sat_delay: assert property ((sat ##2 moveRd) |=> rdData_q[9])
        else $error("saturation flag late");
    chk_sat_prio: assert property (sat ##1 (moveWr.wrEn && !moveWr.wrData[9])
        ##1 (moveRd && !moveWr.wrEn) |=> rdData_q[9]) else $error("clear beat saturation set");
    chk_endian_bit: assert property (moveRd |=> rdData_q[8] == endianPin)
        else $error("endian bit wrong");
    chk_enable_write: assert property ((moveWr.wrEn && !intTaken && !intReturn ##1 quiet)
        |=> maskableAllow_q == $past(moveWr.wrData[0], 2)) else $error("enable not applied");
    chk_reset_enable: assert property ($rose(nrst) |-> !maskableAllow_q ##1 !maskableAllow_q)
        else $error("enable set after reset");
    chk_int_save: assert property ((intTaken ##1 (moveRd && quiet))
        |=> rdData_q[1:0] == {$past(maskableAllow_q), 1'b0}) else $error("saved enable wrong");
    chk_deep_hold: assert property (sleepState_q inside {CCSR_DEEPER, CCSR_DEEPEST} |=> $stable(sleepState_q))
        else $error("left deep sleep without reset");
    cover property (sat ##2 moveRd);
    cover property (intTaken ##1 moveRd);
    cover property (sleepState_q == CCSR_DEEPEST);
    cover property (sleepState_q == CCSR_LIGHT ##1 sleepState_q == CCSR_AWAKE);
endmodule

// *** verif/ccsr_core_status_tb.sv ***
module ccsr_core_status_tb
    import ccsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    ccsr_move_s  moveWr = '0;
    logic        moveRd = 1'b0;
    logic        satEvent = 1'b0;
    logic        satCondTrue = 1'b1;
    logic        intTaken = 1'b0;
    logic        intReturn = 1'b0;
    logic [11:0] intPending = '0;
    logic [11:0] intEnabled = '0;
    logic        endianPin = 1'b1;
    logic [31:0] rdData_q;
    logic        maskableAllow_q;
    ccsr_sleep_e sleepState_q;
    ccsr_cache_s cache_q;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;
    // Write word, expected read word
    logic [63:0] rows [6] = '{64'hABCD_FE49_5AA5_0149, 64'h0000_0040_5AA5_0140,
        64'h0000_0008_5AA5_0108, 64'h0000_0000_5AA5_0100, 64'h0000_00F7_5AA5_01F7,
        64'h0000_0049_5AA5_0149};
    ccsr_core_status ccsr_core_status_i (.clk(clk), .nrst(nrst), .moveWr(moveWr), .moveRd(moveRd),
        .satEvent(satEvent), .satCondTrue(satCondTrue), .intTaken(intTaken), .intReturn(intReturn),
        .intPending(intPending), .intEnabled(intEnabled), .endianPin(endianPin), .rdData_q(rdData_q),
        .maskableAllow_q(maskableAllow_q), .sleepState_q(sleepState_q), .cache_q(cache_q));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Cache mode values that mean the cache is on
    function automatic logic modeOn(logic [2:0] mode);
        return mode == 3'h0 || mode == 3'h2;
    endfunction
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic rst();
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        check("resetOut", rdData_q | 32'(maskableAllow_q), 32'h0000_0000);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task automatic wr(logic [31:0] d);
        moveWr = {1'b1, d};
        @(negedge clk);
        moveWr.wrEn = 1'b0;
    endtask
    task automatic rd(logic [31:0] exp);
        moveRd = 1'b1;
        @(negedge clk);
        moveRd = 1'b0;
        check("rdData_q", rdData_q, exp);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic sleep(logic [31:0] d, ccsr_sleep_e st);
        wr(d);
        @(negedge clk);
        check("sleepState_q", 32'(sleepState_q), 32'(st));
    endtask
    task automatic wake(logic [11:0] en, ccsr_sleep_e st);
        intPending = 12'h001;
        intEnabled = en;
        repeat (2) @(negedge clk);
        check("wakeState", 32'(sleepState_q), 32'(st));
        intPending = '0;
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rst();
        rd(32'h5AA5_0100);
        check("cache_q", 32'(cache_q), 32'h0000_0003);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i][63:32]);
            rd(rows[i][31:0]);
            check("cache_q", 32'(cache_q),
                  {24'h0, rows[i][7:2], modeOn(rows[i][7:5]), modeOn(rows[i][4:2])});
            check("allow", 32'(maskableAllow_q), 32'(rows[i][0]));
        end
        pulse(satEvent);
        moveRd = 1'b1;
        @(negedge clk);
        check("satEarly", 32'(rdData_q[9]), 32'h0000_0000);
        @(negedge clk);
        moveRd = 1'b0;
        check("satSet", 32'(rdData_q[9]), 32'h0000_0001);
        wr(32'h0000_0049);
        rd(32'h5AA5_0149);
        // Clear lands on the same edge as the pending set
        pulse(satEvent);
        wr(32'h0000_0049);
        rd(32'h5AA5_0349);
        wr(32'h0000_0049);
        satCondTrue = 1'b0;
        pulse(satEvent);
        repeat (2) @(negedge clk);
        rd(32'h5AA5_0149);
        pulse(intTaken);
        rd(32'h5AA5_014A);
        pulse(intReturn);
        @(negedge clk);
        check("allow", 32'(maskableAllow_q), 32'h0000_0001);
        sleep(32'h0000_2449, CCSR_LIGHT);
        rd(32'h5AA5_0149);
        wake(12'h000, CCSR_LIGHT);
        wake(12'h001, CCSR_AWAKE);
        sleep(32'h0000_4449, CCSR_LIGHT);
        wake(12'h000, CCSR_AWAKE);
        sleep(32'h0000_0C49, CCSR_AWAKE);
        sleep(32'h0000_6849, CCSR_DEEPER);
        sleep(32'h0000_0049, CCSR_DEEPER);
        wake(12'h001, CCSR_DEEPER);
        rst();
        check("sleepState_q", 32'(sleepState_q), 32'(CCSR_AWAKE));
        sleep(32'h0000_7049, CCSR_DEEPEST);
        endianPin = 1'b0;
        rst();
        rd(32'h5AA5_0000);
        end_of_test();
    end
endmodule

bind ccsr_core_status ccsr_core_status_chk #(.CORE_ID(CORE_ID), .REV_ID(REV_ID)) ccsr_core_status_chk_i (
    .clk(clk), .nrst(nrst), .moveWr(moveWr), .moveRd(moveRd), .satEvent(satEvent), .satCondTrue(satCondTrue),
    .intTaken(intTaken), .intReturn(intReturn), .endianPin(endianPin), .rdData_q(rdData_q),
    .maskableAllow_q(maskableAllow_q), .sleepState_q(sleepState_q));
